// >>> hw/terl_top.sv
// top of timer event request logic: apb registers, counter, flags, requests
// assumes apb master on clock, tick and capture pin from outside domain logic
//
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module terl_top
    import terl_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire terl_pkg::terl_apb_req_s apbReq,
    output terl_pkg::terl_apb_rsp_s apbRsp,
    input wire logic tick,
    input wire logic timerInputPin,
    input wire logic dmaAck,
    output logic irqReq,
    output logic dmaReq,
    output logic irq
);
    // ****************************************
    // reset release
    // ****************************************
    logic [1:0] rstSync;
    logic rstN;
    // synchronise reset release
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rstSync <= 2'h0;
        end else begin
            rstSync <= {rstSync[0], 1'b1};
        end
    end
    assign rstN = rstSync[1];

    // ****************************************
    // state
    // ****************************************
    terl_state_s st;
    terl_state_s next_st;
    terl_req_s route;
    logic wr;
    logic rd;
    logic refHit;
    logic capHit;
    logic pinNow;
    logic pinOld;
    logic [1:0] w1c;
    logic [1:0] ackClr;

    // request mapping
    terl_route u_route (
        .flags(st.flags),
        .dmaEnable(st.mode[BIT_DMA_EN]),
        .refEnable(st.refEnable),
        .edgeSel(st.edgeSel),
        .req(route)
    );

    // decode strobes and events
    assign wr = apbReq.psel & apbReq.penable & apbReq.pwrite;
    assign rd = apbReq.psel & ~apbReq.penable & ~apbReq.pwrite;
    assign pinNow = st.pinSync[1];
    assign pinOld = st.pinSync[2];
    // full 32-bit compare at the tick
    assign refHit = tick & (st.counter == st.compare);
    // edge detect per edge select
    always_comb begin
        unique case (st.edgeSel)
            EDGE_OFF: capHit = 1'b0;
            EDGE_RISE: capHit = pinNow & ~pinOld;
            EDGE_FALL: capHit = ~pinNow & pinOld;
            EDGE_ANY: capHit = pinNow ^ pinOld;
        endcase
    end
    // write one to clear, and dma acknowledge clears both while dma is enabled
    assign w1c = (wr && apbReq.paddr == ADDR_EVENT) ? apbReq.pwdata[1:0] : 2'h0;
    assign ackClr = (dmaAck & st.mode[BIT_DMA_EN]) ? 2'h3 : 2'h0;

    // next state
    always_comb begin
        logic [1:0] evt;
        logic [31:0] stepped;
        evt = 2'h0;
        stepped = 32'h0;
        next_st = st;
        next_st.pinSync = {st.pinSync[1:0], timerInputPin};
        evt[BIT_REF] = refHit;
        evt[BIT_CAP] = capHit;
        // counter step, wide mode mirrors halves
        if (tick) begin
            stepped = st.counter + (st.mode[BIT_WIDE] ? STEP_WIDE : STEP_NARROW);
            if (st.mode[BIT_WIDE]) begin
                stepped[31:HALF] = stepped[HALF-1:0];
            end
            next_st.counter = stepped;
        end
        // flags set win over clears, independent of enables
        next_st.flags = (st.flags & ~(w1c | ackClr)) | evt;
        next_st.irqStatus = (st.irqStatus & ~((wr && apbReq.paddr == ADDR_IRQ_CLEAR) ?
            apbReq.pwdata[1:0] : 2'h0)) | evt;
        // register writes
        if (wr) begin
            unique case (apbReq.paddr)
                ADDR_MODE: next_st.mode = apbReq.pwdata[7:0] & MODE_MASK;
                ADDR_CTRL: begin
                    next_st.refEnable = apbReq.pwdata[CTRL_REF_EN];
                    next_st.edgeSel = terl_edge_e'(apbReq.pwdata[CTRL_EDGE_LO+1:CTRL_EDGE_LO]);
                end
                ADDR_COMPARE: next_st.compare = apbReq.pwdata;
                ADDR_COUNTER: next_st.counter = 32'h0;
                ADDR_IRQ_ENABLE: next_st.irqEnable = apbReq.pwdata[1:0];
                default: ;
            endcase
        end
        // wide mode keeps the halves mirrored at all times, also right after the mode is set
        if (next_st.mode[BIT_WIDE]) begin
            next_st.counter[31:HALF] = next_st.counter[HALF-1:0];
        end
        // read data in setup, ready in access
        next_st.rsp.pready = apbReq.psel & ~apbReq.penable;
        next_st.rsp.pslverr = 1'b0;
        if (rd) begin
            unique case (apbReq.paddr)
                ADDR_MODE: next_st.rsp.prdata = {24'h0, st.mode};
                ADDR_EVENT: next_st.rsp.prdata = {30'h0, st.flags};
                ADDR_CTRL: next_st.rsp.prdata = {29'h0, st.edgeSel, st.refEnable};
                ADDR_COMPARE: next_st.rsp.prdata = st.compare;
                ADDR_COUNTER: next_st.rsp.prdata = st.counter;
                ADDR_IRQ_STATUS: next_st.rsp.prdata = {30'h0, st.irqStatus};
                ADDR_IRQ_ENABLE: next_st.rsp.prdata = {30'h0, st.irqEnable};
                default: next_st.rsp.prdata = 32'h0;
            endcase
        end else if (!apbReq.psel) begin
            next_st.rsp.prdata = 32'h0;
        end
        // requests follow the flags one cycle later
        next_st.req = route;
        next_st.irq = |(st.irqStatus & st.irqEnable);
    end

    // register all state
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            st <= '{mode: MODE_RESET, flags: 2'h0, refEnable: 1'b0, edgeSel: EDGE_OFF,
                compare: COMPARE_RESET, counter: 32'h0, irqStatus: 2'h0, irqEnable: 2'h0,
                pinSync: 3'h0, rsp: '0, req: '0, irq: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign apbRsp = st.rsp;
    assign irqReq = st.req.irqReq;
    assign dmaReq = st.req.dmaReq;
    assign irq = st.irq;

    // ****************************************
    // checks
    // ****************************************
    chk_ref_set: assert property (@(posedge clock) disable iff (!rstN) refHit |=> st.flags[BIT_REF])
        else $error("reference flag not set on match");
    chk_cap_set: assert property (@(posedge clock) disable iff (!rstN) capHit |=> st.flags[BIT_CAP])
        else $error("capture flag not set on edge");
    chk_w1c_clear: assert property (@(posedge clock) disable iff (!rstN)
        (w1c[BIT_REF] && !refHit) |=> !st.flags[BIT_REF])
        else $error("write one did not clear flag");
    chk_ack_clear: assert property (@(posedge clock) disable iff (!rstN)
        (dmaAck && st.mode[BIT_DMA_EN] && !refHit && !capHit) |=> st.flags == 2'h0)
        else $error("dma acknowledge did not clear flags");
    chk_wide_mirror: assert property (@(posedge clock) disable iff (!rstN)
        st.mode[BIT_WIDE] |-> st.counter[31:HALF] == st.counter[HALF-1:0])
        else $error("wide step halves differ");
    chk_step_one: assert property (@(posedge clock) disable iff (!rstN)
        (tick && !st.mode[BIT_WIDE] && !wr) |=> st.counter == $past(st.counter) + STEP_NARROW)
        else $error("narrow step wrong");
    chk_ref_gate: assert property (@(posedge clock) disable iff (!rstN)
        (st.flags == 2'h2 && !st.refEnable) |=> !(st.req.irqReq || st.req.dmaReq))
        else $error("reference request without enable");
    chk_cap_off: assert property (@(posedge clock) disable iff (!rstN)
        (st.flags == 2'h1 && st.edgeSel == EDGE_OFF) |=> !(st.req.irqReq || st.req.dmaReq))
        else $error("capture request with edge select off");
    chk_irq_route: assert property (@(posedge clock) disable iff (!rstN)
        (st.flags[BIT_CAP] && st.edgeSel != EDGE_OFF && !st.mode[BIT_DMA_EN]) |=> st.req.irqReq)
        else $error("capture interrupt missing");
    chk_dma_route: assert property (@(posedge clock) disable iff (!rstN)
        (st.flags[BIT_CAP] && st.edgeSel == EDGE_ANY && st.mode[BIT_DMA_EN]) |=> st.req.dmaReq && !st.req.irqReq)
        else $error("capture dma missing");
    chk_irq_drop: assert property (@(posedge clock) disable iff (!rstN)
        (st.flags == 2'h0) |=> !st.req.irqReq && !st.req.dmaReq)
        else $error("request held after flags cleared");
endmodule
`default_nettype wire

// >>> hw/terl_pkg.sv
// package of constants and carrier types for the timer event and request logic
// assumes a 32-bit apb master and one bus clock
// Functional notes
// - dma enable bit 7 routes enabled events to dma, else to interrupt
// - wide step bit 0: tick adds 1, or 65537 when set
// - in wide step mode upper counter half equals lower half
// - compare always uses all 32 counter bits against compare value
// - event flags set regardless of dma or reference enable; edge select 00 stops capture flag
// - writing 1 clears a flag, 0 leaves it; each flag clears on its own bit
// - dma acknowledge clears both flags when dma requests are in use
// - reference flag bit 1 sets when counter equals compare value
// - reference flag requests only with its enable; irq or dma per dma bit
// - capture flag with edge select 00 makes no request
// - capture flag with edge select 01 or 10 requests irq or dma
// - capture flag with edge select 11 requests irq or dma
// - interrupt request drops once causing flags clear
// - edge select: 00 off, 01 rising, 10 falling, 11 any edge
// - reference enable gates only reference requests, not capture ones
// - capture flag is bit 0, so writing 0x03 clears both flags
package terl_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [11:0] ADDR_MODE = 12'h000;
    localparam logic [11:0] ADDR_EVENT = 12'h004;
    localparam logic [11:0] ADDR_CTRL = 12'h008;
    localparam logic [11:0] ADDR_COMPARE = 12'h00c;
    localparam logic [11:0] ADDR_COUNTER = 12'h010;
    localparam logic [11:0] ADDR_IRQ_STATUS = 12'h014;
    localparam logic [11:0] ADDR_IRQ_ENABLE = 12'h018;
    localparam logic [11:0] ADDR_IRQ_CLEAR = 12'h01c;
    localparam int BIT_DMA_EN = 7;
    localparam int BIT_WIDE = 0;
    localparam int BIT_REF = 1;
    localparam int BIT_CAP = 0;
    localparam logic [7:0] MODE_MASK = 8'h81;
    localparam int CTRL_REF_EN = 0;
    localparam int CTRL_EDGE_LO = 1;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [31:0] COMPARE_RESET = 32'hffffffff;
    localparam logic [31:0] STEP_NARROW = 32'h00000001;
    localparam logic [31:0] STEP_WIDE = 32'h00010001;
    localparam int HALF = 16;
    // ****************************************
    // types
    // ****************************************
    typedef enum logic [1:0] {EDGE_OFF, EDGE_RISE, EDGE_FALL, EDGE_ANY} terl_edge_e;
    typedef struct packed {
        logic [11:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } terl_apb_req_s;
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } terl_apb_rsp_s;
    typedef struct packed {
        logic irqReq;
        logic dmaReq;
    } terl_req_s;
    typedef struct packed {
        logic [7:0] mode;
        logic [1:0] flags;
        logic refEnable;
        terl_edge_e edgeSel;
        logic [31:0] compare;
        logic [31:0] counter;
        logic [1:0] irqStatus;
        logic [1:0] irqEnable;
        logic [2:0] pinSync;
        terl_apb_rsp_s rsp;
        terl_req_s req;
        logic irq;
    } terl_state_s;
endpackage

// >>> hw/terl_route.sv
// request router: maps flags and enables onto interrupt or dma request
// assumes all inputs are registered state of the same clock
`timescale 1ns/10ps
`default_nettype none
module terl_route
    import terl_pkg::*;
(
    input wire logic [1:0] flags,
    input wire logic dmaEnable,
    input wire logic refEnable,
    input wire terl_pkg::terl_edge_e edgeSel,
    output terl_pkg::terl_req_s req
);
    logic refWant;
    logic capWant;
    // reference request gated only by its own enable
    assign refWant = flags[BIT_REF] & refEnable;
    // capture request needs a non-off edge select
    assign capWant = flags[BIT_CAP] & (edgeSel != EDGE_OFF);
    // steer to dma or interrupt
    assign req.dmaReq = (refWant | capWant) & dmaEnable;
    assign req.irqReq = (refWant | capWant) & ~dmaEnable;
endmodule
`default_nettype wire

// >>> test/terl_dma_model.sv
// dma controller model: acknowledges a pending dma request
// assumes dmaReq is a level on the bus clock
`timescale 1ns/10ps
`default_nettype none
module terl_dma_model (
    input wire logic clock,
    input wire logic nrst,
    input wire logic dmaReq,
    input wire logic [3:0] ackDelay,
    output logic dmaAck
);
    logic [3:0] waitCount;
    // ****************************************
    // acknowledge after ackDelay+1 cycles of request
    // ****************************************
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            waitCount <= 4'h0;
            dmaAck <= 1'b0;
        end else begin
            dmaAck <= 1'b0;
            if (dmaReq && !dmaAck) begin
                if (waitCount == ackDelay) begin
                    dmaAck <= 1'b1;
                    waitCount <= 4'h0;
                end else begin
                    waitCount <= waitCount + 4'h1;
                end
            end else begin
                waitCount <= 4'h0;
            end
        end
    end
endmodule
`default_nettype wire

// >>> test/test_timer_event_request_logic.sv
// testbench: apb register tests of terl_top with a dma model
// assumes apb answers with pready, bus clock of 250 MHz
`timescale 1ns/10ps
`default_nettype none
module test_timer_event_request_logic import terl_pkg::*;;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic tick = 1'b0;
    logic timerPin = 1'b0;
    logic [3:0] ackDelay = 4'h6;
    terl_apb_req_s apbReq = '0;
    terl_apb_rsp_s apbRsp;
    logic irqReq, dmaReq, irq, dmaAck, dm, ren;
    logic [31:0] q;
    int miscompares = 0;
    int cmp_count = 0;
    // ****************************************
    // clock, design and partner
    // ****************************************
    always #2 clock = ~clock;
    terl_top dut (.clock(clock), .nrst(nrst), .apbReq(apbReq), .apbRsp(apbRsp), .tick(tick),
        .timerInputPin(timerPin), .dmaAck(dmaAck), .irqReq(irqReq), .dmaReq(dmaReq), .irq(irq));
    terl_dma_model dma (.clock(clock), .nrst(nrst), .dmaReq(dmaReq), .ackDelay(ackDelay),
        .dmaAck(dmaAck));
    // ****************************************
    // tasks
    // ****************************************
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    // one apb transfer, read data left in q
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clock);
        apbReq.paddr <= a;
        apbReq.pwrite <= w;
        apbReq.pwdata <= d;
        apbReq.psel <= 1'b1;
        @(posedge clock);
        apbReq.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (apbRsp.pready !== 1'b1 && n < 50);
        q = apbRsp.prdata;
        chk("pslverr", {31'h0, apbRsp.pslverr}, 0);
        apbReq.psel <= 1'b0;
        apbReq.penable <= 1'b0;
        if (n >= 50) miscompares++;
    endtask
    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge clock) tick <= 1'b1;
            @(posedge clock) tick <= 1'b0;
        end
        repeat (3) @(posedge clock);
    endtask
    task automatic pinEdge();
        @(posedge clock) timerPin <= ~timerPin;
        repeat (8) @(posedge clock);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // watchdog against a hang
    initial begin
        repeat (30000) @(posedge clock);
        miscompares++;
        end_of_test();
    end
    // ****************************************
    // tests
    // ****************************************
    initial begin
        repeat (12) @(posedge clock);
        nrst <= 1'b1;
        repeat (4) @(posedge clock);
        xfer(1'b0, ADDR_MODE, 0);
        chk("mode", q, 0);
        xfer(1'b0, ADDR_COMPARE, 0);
        chk("compare", q, COMPARE_RESET);
        xfer(1'b1, ADDR_MODE, 32'h81);
        xfer(1'b0, ADDR_MODE, 0);
        chk("mode mask", q, 32'h81);
        xfer(1'b1, ADDR_CTRL, 32'h7);
        xfer(1'b0, ADDR_CTRL, 0);
        chk("ctrl", q, 32'h7);
        xfer(1'b0, 12'h100, 0);
        chk("unmapped", q, 0);
        $display("test registers done");
        xfer(1'b1, ADDR_MODE, 1);
        xfer(1'b1, ADDR_COUNTER, 0);
        xfer(1'b1, ADDR_COMPARE, 1);
        xfer(1'b1, ADDR_EVENT, 3);
        pulse(2);
        xfer(1'b0, ADDR_COUNTER, 0);
        chk("wide count", q, 32'h00020002);
        xfer(1'b0, ADDR_EVENT, 0);
        chk("wide ref", q, 0);
        $display("test wide step done");
        // reference match: irq, slow dma, disabled, fast dma
        for (int i = 0; i < 4; i++) begin
            ackDelay <= (i == 3) ? 4'h0 : 4'h6;
            dm = (i == 1 || i == 3);
            ren = (i != 2);
            xfer(1'b1, ADDR_MODE, {24'h0, dm, 7'h0});
            xfer(1'b1, ADDR_CTRL, {31'h0, ren});
            xfer(1'b1, ADDR_COMPARE, 2);
            xfer(1'b1, ADDR_COUNTER, 0);
            xfer(1'b1, ADDR_EVENT, 3);
            pulse(3);
            if (i < 3) begin
                chk("irqReq", irqReq, ren && !dm);
                chk("dmaReq", dmaReq, ren && dm);
            end
            repeat (12) @(posedge clock);
            xfer(1'b1, ADDR_EVENT, 1);
            xfer(1'b0, ADDR_EVENT, 0);
            chk("ref flag", q, (ren && dm) ? 0 : 2);
            xfer(1'b1, ADDR_EVENT, 3);
            repeat (3) @(posedge clock);
            chk("req drop", {irqReq, dmaReq}, 0);
        end
        $display("test reference done");
        // capture for every edge select, reference enable off
        xfer(1'b1, ADDR_MODE, 0);
        xfer(1'b1, ADDR_IRQ_ENABLE, 1);
        xfer(1'b0, ADDR_IRQ_ENABLE, 0);
        chk("irq enable", q, 1);
        for (int i = 0; i < 4; i++) begin
            xfer(1'b1, ADDR_CTRL, 32'(i << 1));
            xfer(1'b1, ADDR_EVENT, 3);
            xfer(1'b1, ADDR_IRQ_CLEAR, 3);
            pinEdge();
            pinEdge();
            chk("cap irqReq", irqReq, i != 0);
            if (i != 0) chk("irq", irq, 1);
            xfer(1'b1, ADDR_EVENT, 1);
            xfer(1'b1, ADDR_IRQ_CLEAR, 1);
            repeat (3) @(posedge clock);
            chk("cap drop", {irqReq, irq}, 0);
        end
        xfer(1'b1, ADDR_IRQ_ENABLE, 0);
        pinEdge();
        chk("irq mask", irq, 0);
        xfer(1'b0, ADDR_IRQ_STATUS, 0);
        chk("status", q, 1);
        // stale capture flag with edge select off requests nothing
        xfer(1'b1, ADDR_CTRL, 0);
        repeat (3) @(posedge clock);
        chk("cap off irqReq", irqReq, 0);
        xfer(1'b1, ADDR_MODE, 32'h80);
        repeat (3) @(posedge clock);
        chk("cap off dmaReq", dmaReq, 0);
        xfer(1'b0, ADDR_EVENT, 0);
        chk("cap kept", q, 1);
        // any edge with dma on: dma request, then the acknowledge clears the flags
        ackDelay <= 4'h6;
        xfer(1'b1, ADDR_CTRL, 32'h6);
        repeat (3) @(posedge clock);
        chk("cap dmaReq", {irqReq, dmaReq}, 1);
        repeat (8) @(posedge clock);
        xfer(1'b0, ADDR_EVENT, 0);
        chk("ack clear", q, 0);
        chk("dma drop", dmaReq, 0);
        $display("test capture done");
        end_of_test();
    end
endmodule
`default_nettype wire
